/* inc/filter_load_pkg.sv */
package filter_load_pkg;
	// Register byte offsets (index times four)
	localparam logic [7:0] OFS_COMMAND    = 8'h00;
	localparam logic [7:0] OFS_INT_MASK   = 8'h10;
	localparam logic [7:0] OFS_INT_STATUS = 8'h14;
	localparam logic [7:0] OFS_PAGE_BASE  = 8'h50;
	localparam logic [7:0] OFS_ENTRY_PTR  = 8'h84;
	localparam logic [7:0] OFS_PORT_HIGH  = 8'h88;
	localparam logic [7:0] OFS_PORT_MID   = 8'h8C;
	localparam logic [7:0] OFS_PORT_LOW   = 8'h90;
	localparam logic [7:0] OFS_ENABLE     = 8'h94;
	localparam logic [7:0] OFS_DESC_PTR   = 8'h98;
	localparam logic [7:0] OFS_DESC_COUNT = 8'h9C;
	// Field positions and count field width
	localparam int BIT_CMD_LOAD    = 9;
	localparam int BIT_CMD_SWRESET = 7;
	localparam int BIT_LOAD_DONE   = 12;
	localparam int COUNT_BITS      = 5;
	// Reset values and words per descriptor
	localparam logic [15:0] RST_COMMAND = 16'h0080;
	localparam logic [15:0] RST_WORD    = 16'h0000;
	localparam logic [3:0]  WORDS_PER_DESC = 4'h4;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_WAIT  = 3'b001,
		ST_REQ   = 3'b010,
		ST_STORE = 3'b011,
		ST_DONE  = 3'b100
	} load_state_t;
endpackage : filter_load_pkg

/* src/filter_entry_mem.sv */
`timescale 1ns/100ps
// Sixteen entries, three 16-bit cells each; read data registered
module filter_entry_mem #(
	parameter int ENTRIES = 16
) (
	input  wire logic                       clock_i,
	input  wire logic                       wr_en_i,
	input  wire logic [$clog2(ENTRIES)-1:0] wr_entry_i,
	input  wire logic [1:0]                 wr_cell_i,
	input  wire logic [15:0]                wr_data_i,
	input  wire logic [$clog2(ENTRIES)-1:0] rd_entry_i,
	input  wire logic [1:0]                 rd_cell_i,
	output logic      [15:0]                rd_data_o
);
	logic [15:0] cell_mem [0:ENTRIES*3-1];

	function automatic int cell_index(input logic [$clog2(ENTRIES)-1:0] e,
	                                  input logic [1:0] c);
		return int'(e) * 3 + int'(c);
	endfunction : cell_index

	initial begin
		if (ENTRIES < 2 || ENTRIES > 16)
			$error("ENTRIES out of range");
	end

	always_ff @(posedge clock_i) begin
		if (wr_en_i && wr_cell_i != 2'd3)
			cell_mem[cell_index(wr_entry_i, wr_cell_i)] <= wr_data_i;
	end

	always_ff @(posedge clock_i) begin
		if (rd_cell_i == 2'd3)
			rd_data_o <= 16'h0000;
		else
			rd_data_o <= cell_mem[cell_index(rd_entry_i, rd_cell_i)];
	end
endmodule : filter_entry_mem

/* src/filter_load_dma.sv */
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/100ps
module filter_load_dma
	import filter_load_pkg::*;
#(
	parameter int ENTRIES = 16
) (
	input  wire logic        clock_i,
	input  wire logic        rst_b_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	output logic             mem_req_o,
	output logic      [31:0] mem_addr_o,
	input  wire logic        mem_ack_i,
	input  wire logic [15:0] mem_rdata_i,
	input  wire logic        link_busy_i,
	input  wire logic [47:0] match_addr_i,
	output logic             match_hit_o,
	output logic             irq_o
);
	import filter_load_pkg::*;

	localparam int EW = $clog2(ENTRIES);

	load_state_t        state_ff;
	logic [15:0]        command_ff;
	logic [15:0]        int_mask_ff;
	logic [15:0]        int_status_ff;
	logic [15:0]        page_base_ff;
	logic [15:0]        desc_ptr_ff;
	logic [15:0]        desc_count_ff;
	logic [15:0]        entry_ptr_ff;
	logic [15:0]        enable_ff;
	logic [1:0]         word_ff;
	logic               mask_phase_ff;
	logic               busy_s1_ff;
	logic               busy_s2_ff;
	logic               ack_s1_ff;
	logic               ack_s2_ff;
	logic [15:0]        rdata_s1_ff;
	logic [15:0]        rdata_s2_ff;
	logic               rd_pend_ff;
	logic [47:0]        entry_shadow [0:ENTRIES-1];
	logic [15:0]        mem_rd_data;
	logic               cell_wr;
	logic               word_take;
	logic [1:0]         cell_sel;
	logic               apb_setup;
	logic               apb_wr;
	logic               done_evt;
	logic [15:0]        nxt_rdata;
	logic               nxt_hit;

	initial begin
		if (ENTRIES != 16)
			$error("ENTRIES must match the 16-bit enable mask");
	end

	// Memory bus inputs come from outside this clock domain
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			busy_s1_ff  <= 1'b0;
			busy_s2_ff  <= 1'b0;
			ack_s1_ff   <= 1'b0;
			ack_s2_ff   <= 1'b0;
			rdata_s1_ff <= RST_WORD;
			rdata_s2_ff <= RST_WORD;
		end else begin
			busy_s1_ff  <= link_busy_i;
			busy_s2_ff  <= busy_s1_ff;
			ack_s1_ff   <= mem_ack_i;
			ack_s2_ff   <= ack_s1_ff;
			rdata_s1_ff <= mem_rdata_i;
			rdata_s2_ff <= rdata_s1_ff;
		end
	end

	assign apb_setup = psel_i && !penable_i;
	assign apb_wr    = psel_i && penable_i && pwrite_i && pready_o;
	assign done_evt  = state_ff == ST_DONE;
	// A word is taken once, on the edge that first sees the synced ack
	assign word_take = state_ff == ST_REQ && mem_req_o && ack_s2_ff;
	// Word position zero is the pointer, 1..3 map to low, mid, high
	assign cell_sel  = word_ff - 2'd1;
	assign cell_wr   = word_take && !mask_phase_ff
	                   && word_ff != 2'd0;

	// Sequencer
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_ff      <= ST_IDLE;
			word_ff       <= 2'd0;
			mask_phase_ff <= 1'b0;
			mem_req_o     <= 1'b0;
			mem_addr_o    <= 32'h0000_0000;
		end else begin
			case (state_ff)
				ST_IDLE: begin
					if (command_ff[BIT_CMD_LOAD] && !command_ff[BIT_CMD_SWRESET])
						state_ff <= ST_WAIT;
				end
				ST_WAIT: begin
					if (!busy_s2_ff) begin
						state_ff      <= ST_REQ;
						word_ff       <= 2'd0;
						mask_phase_ff <= desc_count_ff[COUNT_BITS-1:0] == '0;
					end
				end
				ST_REQ: begin
					if (word_take) begin
						mem_req_o <= 1'b0;
						state_ff  <= ST_STORE;
					end else if (!mem_req_o && !busy_s2_ff) begin
						mem_req_o  <= 1'b1;
						mem_addr_o <= {page_base_ff, desc_ptr_ff};
					end
				end
				ST_STORE: begin
					// Wait for ack to drop so one handshake is not seen twice
					if (!ack_s2_ff) begin
						if (mask_phase_ff)
							state_ff <= ST_DONE;
						else if (word_ff == 2'd3) begin
							word_ff       <= 2'd0;
							mask_phase_ff <= desc_count_ff[COUNT_BITS-1:0] == 5'd0;
							state_ff      <= ST_REQ;
						end else begin
							word_ff  <= word_ff + 2'd1;
							state_ff <= ST_REQ;
						end
					end
				end
				ST_DONE:
					state_ff <= ST_IDLE;
				default:
					state_ff <= ST_IDLE;
			endcase
		end
	end

	// Pointer, count, entry pointer and enable mask
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			desc_ptr_ff   <= RST_WORD;
			desc_count_ff <= RST_WORD;
			entry_ptr_ff  <= RST_WORD;
			enable_ff     <= RST_WORD;
		end else if (word_take) begin
			desc_ptr_ff <= desc_ptr_ff + 16'h0002;
			if (mask_phase_ff)
				enable_ff <= rdata_s2_ff;
			else if (word_ff == 2'd0)
				entry_ptr_ff <= rdata_s2_ff;
			if (!mask_phase_ff && word_ff == 2'd3)
				desc_count_ff <= {11'h000,
				                  desc_count_ff[COUNT_BITS-1:0] - 5'd1};
		end else if (apb_wr) begin
			if (paddr_i == OFS_DESC_PTR)
				desc_ptr_ff <= pwdata_i[15:0];
			if (paddr_i == OFS_DESC_COUNT)
				desc_count_ff <= {11'h000, pwdata_i[COUNT_BITS-1:0]};
			if (paddr_i == OFS_ENTRY_PTR && command_ff[BIT_CMD_SWRESET])
				entry_ptr_ff <= pwdata_i[15:0];
		end
	end

	// Command, page base and interrupt registers
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			command_ff    <= RST_COMMAND;
			page_base_ff  <= RST_WORD;
			int_mask_ff   <= RST_WORD;
			int_status_ff <= RST_WORD;
		end else begin
			if (apb_wr && paddr_i == OFS_COMMAND)
				// A finishing load drops its bit even under a command write
				command_ff <= pwdata_i[15:0]
				              | (done_evt ? 16'h0000 : command_ff & 16'h0200);
			else if (done_evt)
				command_ff[BIT_CMD_LOAD] <= 1'b0;
			if (apb_wr && paddr_i == OFS_PAGE_BASE)
				page_base_ff <= pwdata_i[15:0];
			if (apb_wr && paddr_i == OFS_INT_MASK)
				int_mask_ff <= pwdata_i[15:0];
			if (apb_wr && paddr_i == OFS_INT_STATUS)
				int_status_ff <= int_status_ff & ~pwdata_i[15:0];
			if (done_evt)
				int_status_ff[BIT_LOAD_DONE] <= 1'b1;
		end
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i)
			irq_o <= 1'b0;
		else
			irq_o <= |(int_status_ff & int_mask_ff);
	end

	filter_entry_mem #(
		.ENTRIES(ENTRIES)
	) u_cells (
		.clock_i    (clock_i),
		.wr_en_i    (cell_wr),
		.wr_entry_i (entry_ptr_ff[EW-1:0]),
		.wr_cell_i  (cell_sel),
		.wr_data_i  (rdata_s2_ff),
		.rd_entry_i (entry_ptr_ff[EW-1:0]),
		.rd_cell_i  (paddr_i == OFS_PORT_LOW ? 2'd0 :
		             paddr_i == OFS_PORT_MID ? 2'd1 :
		             paddr_i == OFS_PORT_HIGH ? 2'd2 : 2'd3),
		.rd_data_o  (mem_rd_data)
	);

	// Shadow copy for parallel match; the memory gives one cell per cycle
	always_ff @(posedge clock_i) begin
		if (cell_wr)
			entry_shadow[entry_ptr_ff[EW-1:0]][16*cell_sel +: 16]
				<= rdata_s2_ff;
	end

	always_comb begin
		nxt_hit = 1'b0;
		for (int i = 0; i < ENTRIES; i++) begin
			if (enable_ff[i] && entry_shadow[i] == match_addr_i)
				nxt_hit = 1'b1;
		end
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i)
			match_hit_o <= 1'b0;
		else
			match_hit_o <= nxt_hit;
	end

	// APB: one wait state so the cell memory read data is ready
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i)
			rd_pend_ff <= 1'b0;
		else
			rd_pend_ff <= apb_setup;
	end

	always_comb begin
		nxt_rdata = 16'h0000;
		case (paddr_i)
			OFS_COMMAND:    nxt_rdata = command_ff;
			OFS_INT_MASK:   nxt_rdata = int_mask_ff;
			OFS_INT_STATUS: nxt_rdata = int_status_ff;
			OFS_PAGE_BASE:  nxt_rdata = page_base_ff;
			OFS_ENTRY_PTR:  nxt_rdata = entry_ptr_ff;
			OFS_ENABLE:     nxt_rdata = enable_ff;
			OFS_DESC_PTR:   nxt_rdata = desc_ptr_ff;
			OFS_DESC_COUNT: nxt_rdata = desc_count_ff;
			OFS_PORT_LOW, OFS_PORT_MID, OFS_PORT_HIGH:
				nxt_rdata = command_ff[BIT_CMD_SWRESET] ? mem_rd_data
				                                        : 16'h0000;
			default:        nxt_rdata = 16'h0000;
		endcase
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pready_o  <= 1'b0;
			prdata_o  <= 32'h0000_0000;
			pslverr_o <= 1'b0;
		end else begin
			pready_o  <= psel_i && penable_i && rd_pend_ff && !pready_o;
			prdata_o  <= {16'h0000, nxt_rdata};
			pslverr_o <= psel_i && penable_i && rd_pend_ff && paddr_i[1:0] != 2'b00;
		end
	end
endmodule : filter_load_dma

/* verification/filter_load_assertions.sv */
`timescale 1ns/100ps
module filter_load_assertions (
	input wire logic        clock_i,
	input wire logic        rst_b_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic [7:0]  paddr_i,
	input wire logic [31:0] prdata_o,
	input wire logic        pready_o,
	input wire logic        pslverr_o,
	input wire logic        mem_req_o,
	input wire logic [31:0] mem_addr_o,
	input wire logic        mem_ack_i,
	input wire logic        link_busy_i
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_b_i);
	property p_ready_lat;
		$rose(penable_i) && psel_i |-> !pready_o ##1 pready_o;
	endproperty
	a_ready_lat: assert property (p_ready_lat)
		else $error("ready not after one wait state");
	property p_ready_pulse; pready_o |=> !pready_o; endproperty
	a_ready_pulse: assert property (p_ready_pulse)
		else $error("ready held too long");
	property p_err;
		pready_o |-> pslverr_o == (paddr_i[1:0] != 2'h0);
	endproperty
	a_err: assert property (p_err)
		else $error("error flag wrong");
	property p_upper_zero; pready_o |-> prdata_o[31:16] == 16'h0; endproperty
	a_upper_zero: assert property (p_upper_zero)
		else $error("read data upper half set");
	property p_req_hold; mem_req_o && !mem_ack_i |=> mem_req_o; endproperty
	a_req_hold: assert property (p_req_hold)
		else $error("fetch dropped before answer");
	property p_addr_stable;
		mem_req_o && !mem_ack_i |=> $stable(mem_addr_o);
	endproperty
	a_addr_stable: assert property (p_addr_stable)
		else $error("fetch address moved");
	property p_addr_even; mem_req_o |-> !mem_addr_o[0]; endproperty
	a_addr_even: assert property (p_addr_even)
		else $error("fetch address odd");
	// Fetches are gated by busy after its two-flop synchroniser
	property p_busy_defer;
		link_busy_i [*4] |-> !$rose(mem_req_o);
	endproperty
	a_busy_defer: assert property (p_busy_defer)
		else $error("fetch while link busy");
endmodule : filter_load_assertions

bind filter_load_dma filter_load_assertions filter_load_assertions_i (
	.clock_i     (clock_i),
	.rst_b_i     (rst_b_i),
	.psel_i      (psel_i),
	.penable_i   (penable_i),
	.paddr_i     (paddr_i),
	.prdata_o    (prdata_o),
	.pready_o    (pready_o),
	.pslverr_o   (pslverr_o),
	.mem_req_o   (mem_req_o),
	.mem_addr_o  (mem_addr_o),
	.mem_ack_i   (mem_ack_i),
	.link_busy_i (link_busy_i)
);

/* verification/filter_mem_model.sv */
`timescale 1ns/100ps
module filter_mem_model (
	input  wire logic        clock_i,
	input  wire logic        req_i,
	input  wire logic [31:0] addr_i,
	input  wire logic [3:0]  lat_i,
	output logic             ack_o,
	output logic      [15:0] rdata_o
);
	logic [15:0] words [256];
	logic [3:0]  wait_cnt;
	initial begin
		ack_o = 1'b0;
		rdata_o = 16'h0000;
		wait_cnt = 4'h0;
	end
	// Data is void once ack drops, so show its inverse rather than hold it
	always @(posedge clock_i) begin
		if (ack_o && !req_i) begin
			ack_o <= 1'b0;
			rdata_o <= ~rdata_o;
		end else if (!ack_o && req_i && wait_cnt >= lat_i) begin
			ack_o <= 1'b1;
			rdata_o <= words[addr_i[8:1]];
		end
		wait_cnt <= (req_i && !ack_o) ? wait_cnt + 4'h1 : 4'h0;
	end
endmodule : filter_mem_model

/* verification/tb_filter_load_dma.sv */
`timescale 1ns/100ps
module tb_filter_load_dma;
	import filter_load_pkg::*;
	logic clock_i = 1'b0, rst_b_i = 1'b0, link_busy_i = 1'b0;
	logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
	logic [7:0] paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0, prdata_o, mem_addr_o;
	logic pready_o, pslverr_o, mem_req_o, mem_ack_i, match_hit_o, irq_o;
	logic [15:0] mem_rdata_i;
	logic [47:0] match_addr_i = 48'h0;
	logic [3:0] lat = 4'h0;
	logic last_err;
	logic [15:0] img [14] = '{16'h0003, 16'h1111, 16'h2222, 16'h3333,
		16'h0008, 16'h4444, 16'h5555, 16'h6666, 16'h0008,
		16'h0008, 16'h7777, 16'h8888, 16'h9999, 16'h0100};
	int fail_count = 0;
	int compares = 0;
	always #4 clock_i = ~clock_i;
	filter_load_dma filter_load_dma_i (.*);
	filter_mem_model filter_mem_model_i (.clock_i(clock_i), .req_i(mem_req_o),
		.addr_i(mem_addr_o), .lat_i(lat), .ack_o(mem_ack_i),
		.rdata_o(mem_rdata_i));
	task automatic chk(input logic [47:0] g, input logic [47:0] e);
		compares++;
		if (g !== e) begin
			$display("wrong value at %0t: got %0h expected %0h", $time, g, e);
			fail_count++;
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge clock_i);
		psel_i <= 1'b1; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
		@(posedge clock_i);
		penable_i <= 1'b1;
		do @(posedge clock_i); while (pready_o !== 1'b1);
		r = prdata_o;
		last_err = pslverr_o;
		psel_i <= 1'b0; penable_i <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic [31:0] r;
		apb(1'h1, a, {16'h0000, d}, r);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		apb(1'h0, a, 32'h0, r);
		chk(r, e);
	endtask : rd
	task automatic wait_done;
		logic [31:0] r;
		int n;
		n = 0;
		do begin apb(1'h0, OFS_INT_STATUS, 32'h0, r); n++; end
			while (r[BIT_LOAD_DONE] !== 1'b1 && n < 200);
		chk(r[BIT_LOAD_DONE], 1'h1);
		repeat (2) @(posedge clock_i);
	endtask : wait_done
	task automatic hit(input logic [47:0] a, input logic e);
		match_addr_i <= a;
		repeat (4) @(posedge clock_i);
		chk(match_hit_o, e);
	endtask : hit
	task automatic test_done;
		if (fail_count == 0 && compares > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : test_done
	always @(posedge clock_i) if (mem_req_o) chk(mem_addr_o[31:16], 16'h0012);
	task automatic t_regs;
		rd(OFS_COMMAND, {16'h0000, RST_COMMAND});
		chk(last_err, 1'h0);
		rd(8'hFC, 32'h0);
		rd(8'h9E, 32'h0);
		chk(last_err, 1'h1);
	endtask : t_regs
	task automatic t_load1;
		wr(OFS_PAGE_BASE, 16'h0012);
		wr(OFS_DESC_COUNT, 16'hFFE2);
		wr(OFS_DESC_PTR, 16'h0100);
		wr(OFS_INT_MASK, 16'h1000);
		wr(OFS_COMMAND, 16'h0000);
		link_busy_i <= 1'b1;
		wr(OFS_COMMAND, 16'h0200);
		repeat (20) @(posedge clock_i);
		chk(mem_req_o, 1'h0);
		link_busy_i <= 1'b0;
		wait_done;
		chk(irq_o, 1'h1);
		rd(OFS_COMMAND, 32'h0);
		rd(OFS_DESC_COUNT, 32'h0);
		rd(OFS_DESC_PTR, 32'h0112);
		wr(OFS_INT_STATUS, 16'h1000);
		rd(OFS_INT_STATUS, 32'h0);
		chk(irq_o, 1'h0);
	endtask : t_load1
	task automatic t_cells;
		rd(OFS_PORT_LOW, 32'h0);
		hit(48'h333322221111, 1'b1);
		hit(48'h666655554444, 1'b0);
		wr(OFS_COMMAND, 16'h0080);
		wr(OFS_ENTRY_PTR, 16'h0003);
		rd(OFS_PORT_LOW, 32'h1111);
		rd(OFS_PORT_MID, 32'h2222);
		rd(OFS_PORT_HIGH, 32'h3333);
		rd(OFS_ENABLE, 32'h0008);
		wr(OFS_ENTRY_PTR, 16'h0008);
		wr(OFS_PORT_LOW, 16'hBEEF);
		rd(OFS_PORT_LOW, 32'h4444);
	endtask : t_cells
	task automatic t_load2;
		wr(OFS_COMMAND, 16'h0000);
		wr(OFS_INT_MASK, 16'h0000);
		lat <= 4'h5;
		wr(OFS_DESC_COUNT, 16'h0001);
		wr(OFS_DESC_PTR, 16'h0200);
		wr(OFS_COMMAND, 16'h0200);
		wait_done;
		chk(irq_o, 1'h0);
		wr(OFS_INT_MASK, 16'h1000);
		repeat (2) @(posedge clock_i);
		chk(irq_o, 1'h1);
		rd(OFS_DESC_PTR, 32'h020A);
		hit(48'h999988887777, 1'b1);
		hit(48'h333322221111, 1'b0);
	endtask : t_load2
	initial begin
		for (int i = 0; i < 14; i++)
			filter_mem_model_i.words[i < 9 ? 8'h80 + i : i - 9] = img[i];
		repeat (3) @(posedge clock_i);
		rst_b_i <= 1'b1;
		t_regs;
		t_load1;
		t_cells;
		t_load2;
		test_done;
	end
	initial begin
		#200000;
		fail_count++;
		test_done;
	end
endmodule : tb_filter_load_dma
